// ---- inc/dici_pkg.sv ----
// Overview of operation
// RULE1: Volatile write only after data acknowledge clock
// RULE2: NACK invalid address/command or unimplemented address
// RULE3: After error, only a Start restores idle
// RULE4: Commit each data word during its acknowledge
// RULE5: Stop/Restart before acknowledge discards the word
// RULE6: Master ends only after final acknowledge
// RULE7: Continuous writes: command-plus-data groups, any address
// RULE8: Addresses 00,08,09,0A; 01 only when dual
// RULE9: Commands under high voltage flagged, same format
// RULE10: Output register loads when pin leaves high voltage
// RULE11: Reads behave the same under high voltage
// RULE12: Last memory address kept across Stop/Restart
// RULE13: Latch high: DAC reads return output register
// RULE14: Single read: write, command, Restart, read control
// RULE15: Last-address read skips the command byte
// RULE16: Continuous reads end with NACK then Stop
// RULE17: Code 00 is write, 11 is read
// RULE18: Start mid-byte aborts, resets, expects slave address
// RULE19: Undefined command: release data, wait for Start
// RULE20: Command byte: address[4:0], code[1:0], don't-care
// RULE21: Data word is two bytes, high first
package dici_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h60;
  localparam int ADDR_W = 5;
  localparam int WORD_W = 16;
  localparam int MEM_N = 5;
  localparam int IDX_W = 3;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [ADDR_W-1:0] A_CH0 = 5'h00;
  localparam logic [ADDR_W-1:0] A_CH1 = 5'h01;
  localparam logic [ADDR_W-1:0] A_CFG8 = 5'h08;
  localparam logic [ADDR_W-1:0] A_CFG9 = 5'h09;
  localparam logic [ADDR_W-1:0] A_CFGA = 5'h0a;
  localparam logic [IDX_W-1:0] I_CH0 = 3'h0;
  localparam logic [IDX_W-1:0] I_CH1 = 3'h1;
  localparam logic [IDX_W-1:0] I_CFG8 = 3'h2;
  localparam logic [IDX_W-1:0] I_CFG9 = 3'h3;
  localparam logic [IDX_W-1:0] I_CFGA = 3'h4;
  localparam logic [1:0] CC_WRITE = 2'h0;
  localparam logic [1:0] CC_READ = 2'h3;
  localparam logic [WORD_W-1:0] MEM_RST = 16'h0000;
  localparam int MCLK_KHZ = 125000;
  localparam int SCL_KHZ = 400;
  localparam int QUARTER_CYC = MCLK_KHZ / (SCL_KHZ * 4);
  localparam logic [3:0] STOP_WRITE = 4'h5;
  localparam logic [3:0] STOP_READ = 4'h7;
  localparam logic [3:0] STOP_LAST = 4'h4;

  typedef enum logic [1:0] {
    OP_WRITE     = 2'b00,
    OP_READ      = 2'b01,
    OP_READ_LAST = 2'b10
  } dici_op_e;

  typedef enum logic [2:0] {
    IT_START   = 3'b000,
    IT_WR      = 3'b001,
    IT_RD_ACK  = 3'b010,
    IT_RD_NACK = 3'b011,
    IT_STOP    = 3'b100,
    IT_END     = 3'b101
  } dici_item_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CTRL  = 3'b001,
    ST_CMD   = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100
  } dici_state_e;

  // Returns {implemented, storage index}
  function automatic logic [IDX_W:0] mem_slot(input logic [ADDR_W-1:0] a,
                                              input logic dual);
    case (a)
      A_CH0:   mem_slot = {1'b1, I_CH0};
      A_CH1:   mem_slot = {dual, I_CH1};
      A_CFG8:  mem_slot = {1'b1, I_CFG8};
      A_CFG9:  mem_slot = {1'b1, I_CFG9};
      A_CFGA:  mem_slot = {1'b1, I_CFGA};
      default: mem_slot = {1'b0, I_CH0};
    endcase
  endfunction
endpackage

// ---- inc/dici_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface dici_if;
  logic h_scl_o;
  logic h_scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // Open-drain data line with pull-up; clock driven by the host only
  assign scl = h_scl_oe ? h_scl_o : 1'b1;
  assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
  modport host (input sda, output h_scl_o, output h_scl_oe,
                output h_sda_o, output h_sda_oe);
endinterface
`default_nettype wire

// ---- design/dici_dev.sv ----
`timescale 1ns/1ns
`default_nettype none
module dici_dev #(
  parameter bit DUAL = 1'b1
) (
  dici_if.dev                               bus,
  input  wire logic                         i_mclk,
  input  wire logic                         i_reset,
  input  wire logic                         i_latch,
  input  wire logic                         i_hv_level,
  output logic [dici_pkg::WORD_W-1:0]       o_out0,
  output logic [dici_pkg::WORD_W-1:0]       o_out1,
  output logic                              o_hv_write
);
  import dici_pkg::*;

  logic              start_t;
  logic              start_seen;
  logic              next_start_seen;
  dici_state_e       state;
  dici_state_e       next_state;
  logic [3:0]        cnt;
  logic [3:0]        next_cnt;
  logic [7:0]        sr;
  logic [7:0]        next_sr;
  logic [7:0]        wbuf;
  logic [7:0]        next_wbuf;
  logic              lo;
  logic              next_lo;
  logic              ack;
  logic              next_ack;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] next_cur_addr;
  logic [IDX_W-1:0]  cur_idx;
  logic [IDX_W-1:0]  next_cur_idx;
  logic [WORD_W-1:0] tx;
  logic [WORD_W-1:0] next_tx;
  logic [WORD_W-1:0] mem [MEM_N];
  logic [WORD_W-1:0] next_mem [MEM_N];
  logic              hv_cmd;
  logic              next_hv_cmd;
  logic              wr_hv;
  logic              next_wr_hv;
  logic              hv_a;
  logic              hv_b;
  logic              lat_a;
  logic              lat_b;
  logic              oe;
  logic              next_oe;
  logic [7:0]        b;
  logic [IDX_W:0]    slot;
  logic [IDX_W:0]    sslot;
  logic [WORD_W-1:0] rd_word;

  assign bus.d_sda_o  = 1'b0;
  assign bus.d_sda_oe = oe;

  // Start: data falls while clock high; toggles so the link side sees it
  always_ff @(negedge bus.sda or posedge i_reset) begin
    if (i_reset) begin
      start_t <= 1'b0;
    end else if (bus.scl) begin
      start_t <= ~start_t;
    end
  end

  always_comb begin
    rd_word = mem[cur_idx];
    if (lat_b && cur_idx == I_CH0) begin
      rd_word = o_out0; // [RULE13]
    end
    if (lat_b && cur_idx == I_CH1) begin
      rd_word = o_out1; // [RULE13]
    end
  end

  always_comb begin
    next_start_seen = start_seen;
    next_state      = state;
    next_cnt        = cnt;
    next_sr         = sr;
    next_wbuf       = wbuf;
    next_lo         = lo;
    next_ack        = ack;
    next_cur_addr   = cur_addr;
    next_cur_idx    = cur_idx;
    next_tx         = tx;
    next_mem        = mem;
    next_hv_cmd     = hv_cmd;
    next_wr_hv      = wr_hv;
    b     = {sr[6:0], bus.sda};
    slot  = mem_slot(b[7:3], DUAL);
    sslot = mem_slot(sr[7:3], DUAL);
    if (start_t != start_seen) begin
      // Any partial word is dropped; next byte is the slave address
      next_start_seen = start_t; // [RULE3] [RULE18] [RULE5]
      next_state      = ST_CTRL;
      next_sr         = b;
      next_cnt        = 4'h1;
      next_ack        = 1'b0;
      next_lo         = 1'b0;
    end else if (state != ST_IDLE) begin
      if (cnt != ACK_SLOT) begin
        next_sr  = b;
        next_cnt = cnt + 4'h1;
        if (cnt == LAST_BIT) begin
          unique case (state)
            ST_CTRL: begin
              next_ack = (b[7:1] == SLAVE_ADDR);
              if (b[0]) begin
                next_tx = rd_word; // [RULE15] [RULE11]
              end
            end
            ST_CMD: begin
              next_ack = slot[IDX_W] && // [RULE2] [RULE8]
                         (b[2:1] == CC_WRITE || b[2:1] == CC_READ); // [RULE17]
            end
            ST_WDATA: begin
              next_ack = 1'b1;
            end
            default: begin
              next_ack = 1'b0;
            end
          endcase
        end
      end else begin
        next_cnt = 4'h0;
        unique case (state)
          ST_CTRL: begin
            if (!ack) begin
              next_state = ST_IDLE;
            end else if (sr[0]) begin
              next_state = ST_RDATA;
              next_lo    = 1'b0;
            end else begin
              next_state = ST_CMD;
            end
          end
          ST_CMD: begin
            if (!ack) begin
              next_state = ST_IDLE; // [RULE19] [RULE3]
            end else begin
              next_cur_addr = sr[7:3]; // [RULE12] [RULE20]
              next_cur_idx  = sslot[IDX_W-1:0];
              next_hv_cmd   = hv_b; // [RULE9]
              if (sr[2:1] == CC_WRITE) begin
                next_state = ST_WDATA;
                next_lo    = 1'b0;
              end
            end
          end
          ST_WDATA: begin
            if (!lo) begin
              next_wbuf = sr; // [RULE21]
              next_lo   = 1'b1;
            end else begin
              next_mem[cur_idx] = {wbuf, sr}; // [RULE1] [RULE4] [RULE21]
              next_wr_hv        = hv_cmd; // [RULE9]
              next_lo           = 1'b0;
              next_state        = ST_CMD; // [RULE7]
            end
          end
          ST_RDATA: begin
            if (bus.sda) begin
              next_state = ST_IDLE; // [RULE16]
            end else begin
              next_lo = ~lo;
              if (lo) begin
                next_tx = rd_word; // [RULE16]
              end
            end
          end
          default: begin
            next_state = ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge bus.scl or posedge i_reset) begin
    if (i_reset) begin
      start_seen <= 1'b0;
      state      <= ST_IDLE;
      cnt        <= 4'h0;
      sr         <= 8'h00;
      wbuf       <= 8'h00;
      lo         <= 1'b0;
      ack        <= 1'b0;
      cur_addr   <= A_CH0;
      cur_idx    <= I_CH0;
      tx         <= MEM_RST;
      hv_cmd     <= 1'b0;
      wr_hv      <= 1'b0;
      hv_a       <= 1'b0;
      hv_b       <= 1'b0;
      lat_a      <= 1'b0;
      lat_b      <= 1'b0;
      for (int i = 0; i < MEM_N; i++) begin
        mem[i] <= MEM_RST;
      end
    end else begin
      start_seen <= next_start_seen;
      state      <= next_state;
      cnt        <= next_cnt;
      sr         <= next_sr;
      wbuf       <= next_wbuf;
      lo         <= next_lo;
      ack        <= next_ack;
      cur_addr   <= next_cur_addr;
      cur_idx    <= next_cur_idx;
      tx         <= next_tx;
      hv_cmd     <= next_hv_cmd;
      wr_hv      <= next_wr_hv;
      hv_a       <= i_hv_level;
      hv_b       <= hv_a;
      lat_a      <= i_latch;
      lat_b      <= lat_a;
      mem        <= next_mem;
    end
  end

  // Data line changes only while the clock is low
  always_comb begin
    next_oe = 1'b0;
    if (state == ST_RDATA && cnt != ACK_SLOT) begin
      next_oe = ~tx[{~lo, ~cnt[2:0]}];
    end else if (state != ST_RDATA && state != ST_IDLE &&
                 cnt == ACK_SLOT) begin
      next_oe = ack; // [RULE2]
    end
  end

  always_ff @(negedge bus.scl or posedge i_reset) begin
    if (i_reset) begin
      oe <= 1'b0;
    end else begin
      oe <= next_oe;
    end
  end

  // System clock side: latch transfer and status
  logic [2:0] lat_sy;
  logic [2:0] hv_sy;
  logic [1:0] whv_sy;
  logic       lat_f;
  logic       next_lat_f;
  logic       hv_f;
  logic       next_hv_f;
  logic       armed;
  logic       next_armed;
  logic [WORD_W-1:0] next_out0;
  logic [WORD_W-1:0] next_out1;

  // Storage words are stable long before a latch edge is seen here
  always_comb begin
    next_lat_f = (lat_sy[1] == lat_sy[2]) ? lat_sy[2] : lat_f;
    next_hv_f  = (hv_sy[1] == hv_sy[2]) ? hv_sy[2] : hv_f;
    next_armed = armed | hv_f;
    next_out0  = o_out0;
    next_out1  = o_out1;
    if (armed && !lat_f) begin
      next_out0  = mem[I_CH0]; // [RULE10]
      next_out1  = DUAL ? mem[I_CH1] : o_out1; // [RULE10]
      next_armed = hv_f;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      lat_sy     <= 3'h0;
      hv_sy      <= 3'h0;
      whv_sy     <= 2'h0;
      lat_f      <= 1'b0;
      hv_f       <= 1'b0;
      armed      <= 1'b0;
      o_out0     <= MEM_RST;
      o_out1     <= MEM_RST;
      o_hv_write <= 1'b0;
    end else begin
      lat_sy     <= {lat_sy[1:0], i_latch};
      hv_sy      <= {hv_sy[1:0], i_hv_level};
      whv_sy     <= {whv_sy[0], wr_hv};
      lat_f      <= next_lat_f;
      hv_f       <= next_hv_f;
      armed      <= next_armed;
      o_out0     <= next_out0;
      o_out1     <= next_out1;
      o_hv_write <= whv_sy[1];
    end
  end
endmodule // dici_dev
`default_nettype wire

// ---- design/dici_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module dici_host #(
  parameter int QUARTER = dici_pkg::QUARTER_CYC
) (
  dici_if.host                              bus,
  input  wire logic                         i_mclk,
  input  wire logic                         i_reset,
  input  wire logic                         i_req,
  input  wire dici_pkg::dici_op_e           i_op,
  input  wire logic [dici_pkg::ADDR_W-1:0]  i_mem_addr,
  input  wire logic [dici_pkg::WORD_W-1:0]  i_wdata,
  output logic                              o_busy,
  output logic                              o_done,
  output logic                              o_nack,
  output logic [dici_pkg::WORD_W-1:0]       o_rdata
);
  import dici_pkg::*;
  localparam int QW = $clog2(QUARTER + 1);

  dici_op_e          op, next_op;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [WORD_W-1:0] wdata, next_wdata, rxw, next_rxw, next_rdata;
  logic [3:0]        step, next_step, bitn, next_bitn;
  logic [1:0]        ph, next_ph;
  logic [QW-1:0]     qc, next_qc;
  logic              next_busy, next_done, next_nack;
  logic              scl_o, next_scl_o, sda_oe, next_sda_oe;
  logic [2:0]        sy;
  logic              sda_f, next_sda_f;
  dici_item_e        kind;
  logic [7:0]        byt;
  logic [3:0]        stop_step;

  assign bus.h_scl_o  = scl_o;
  assign bus.h_scl_oe = 1'b1;
  assign bus.h_sda_o  = 1'b0;
  assign bus.h_sda_oe = sda_oe;

  // Transaction script, one item per step
  always_comb begin
    kind = IT_END;
    byt  = 8'h00;
    stop_step = STOP_LAST;
    unique case (op)
      OP_WRITE: begin
        stop_step = STOP_WRITE;
        case (step)
          4'h0: kind = IT_START;
          4'h1: begin kind = IT_WR; byt = {SLAVE_ADDR, 1'b0}; end
          4'h2: begin kind = IT_WR; byt = {addr, CC_WRITE, 1'b0}; end // [RULE20]
          4'h3: begin kind = IT_WR; byt = wdata[15:8]; end // [RULE21]
          4'h4: begin kind = IT_WR; byt = wdata[7:0]; end
          4'h5: kind = IT_STOP; // [RULE6]
          default: kind = IT_END;
        endcase
      end
      OP_READ: begin
        stop_step = STOP_READ;
        case (step)
          4'h0: kind = IT_START;
          4'h1: begin kind = IT_WR; byt = {SLAVE_ADDR, 1'b0}; end // [RULE14]
          4'h2: begin kind = IT_WR; byt = {addr, CC_READ, 1'b0}; end
          4'h3: kind = IT_START;
          4'h4: begin kind = IT_WR; byt = {SLAVE_ADDR, 1'b1}; end
          4'h5: kind = IT_RD_ACK;
          4'h6: kind = IT_RD_NACK; // [RULE16]
          4'h7: kind = IT_STOP;
          default: kind = IT_END;
        endcase
      end
      OP_READ_LAST: begin
        case (step)
          4'h0: kind = IT_START;
          4'h1: begin kind = IT_WR; byt = {SLAVE_ADDR, 1'b1}; end // [RULE15]
          4'h2: kind = IT_RD_ACK;
          4'h3: kind = IT_RD_NACK;
          4'h4: kind = IT_STOP;
          default: kind = IT_END;
        endcase
      end
      default: kind = IT_END;
    endcase
  end

  always_comb begin
    next_op = op; next_addr = addr; next_wdata = wdata; next_rxw = rxw;
    next_step = step; next_bitn = bitn; next_ph = ph; next_qc = qc;
    next_busy = o_busy; next_done = 1'b0; next_nack = o_nack;
    next_rdata = o_rdata; next_scl_o = scl_o; next_sda_oe = sda_oe;
    next_sda_f = (sy[1] == sy[2]) ? sy[2] : sda_f;
    if (!o_busy) begin
      if (i_req) begin
        next_op = i_op; next_addr = i_mem_addr; next_wdata = i_wdata;
        next_busy = 1'b1; next_step = 4'h0; next_bitn = 4'h0;
        next_ph = 2'h0; next_qc = QW'(QUARTER - 1); next_nack = 1'b0;
      end
    end else if (qc != '0) begin
      next_qc = qc - QW'(1);
    end else begin
      next_qc = QW'(QUARTER - 1);
      next_ph = ph + 2'h1;
      unique case (kind)
        IT_START, IT_STOP: begin
          case (ph)
            2'h0: next_sda_oe = (kind == IT_STOP);
            2'h1: next_scl_o = 1'b1;
            2'h2: next_sda_oe = (kind == IT_START);
            default: begin
              next_scl_o = (kind == IT_STOP);
              next_step  = step + 4'h1;
            end
          endcase
        end
        IT_END: begin
          next_busy = 1'b0; next_done = 1'b1; next_rdata = rxw;
          next_ph = 2'h0;
        end
        default: begin
          case (ph)
            2'h0: next_sda_oe = (bitn == ACK_SLOT) ? (kind == IT_RD_ACK)
                                : (kind == IT_WR && !byt[~bitn[2:0]]);
            2'h1: next_scl_o = 1'b1;
            2'h2: begin
              if (bitn != ACK_SLOT) begin
                if (kind != IT_WR) next_rxw = {rxw[14:0], sda_f};
              end else if (kind == IT_WR && sda_f) begin
                next_nack = 1'b1;
              end
            end
            default: begin
              next_scl_o = 1'b0;
              if (bitn == ACK_SLOT) begin
                next_bitn = 4'h0;
                next_step = o_nack ? stop_step : step + 4'h1; // [RULE6]
              end else begin
                next_bitn = bitn + 4'h1;
              end
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      op <= OP_WRITE; addr <= '0; wdata <= '0; rxw <= '0;
      step <= 4'h0; bitn <= 4'h0; ph <= 2'h0; qc <= '0;
      o_busy <= 1'b0; o_done <= 1'b0; o_nack <= 1'b0; o_rdata <= '0;
      scl_o <= 1'b1; sda_oe <= 1'b0; sy <= 3'h7; sda_f <= 1'b1;
    end else begin
      op <= next_op; addr <= next_addr; wdata <= next_wdata;
      rxw <= next_rxw; step <= next_step; bitn <= next_bitn;
      ph <= next_ph; qc <= next_qc; o_busy <= next_busy;
      o_done <= next_done; o_nack <= next_nack; o_rdata <= next_rdata;
      scl_o <= next_scl_o; sda_oe <= next_sda_oe;
      sy <= {sy[1:0], bus.sda}; sda_f <= next_sda_f;
    end
  end
endmodule // dici_host
`default_nettype wire

// ---- dv/dici_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module dici_checker (
  input wire logic                         i_mclk,
  input wire logic                         i_reset,
  input wire logic                         scl,
  input wire logic                         sda,
  input wire logic                         d_sda_oe,
  input wire logic                         i_latch,
  input wire logic                         i_hv_level,
  input wire logic [dici_pkg::WORD_W-1:0]  o_out0,
  input wire logic [dici_pkg::WORD_W-1:0]  o_out1,
  input wire logic                         i_req,
  input wire logic                         o_busy,
  input wire logic                         o_done
);
  import dici_pkg::*;
  logic [7:0] since_hv;
  logic [7:0] next_since_hv;

  // Cycles since the pin was last at the high-voltage level
  always_comb begin
    if (i_hv_level) begin
      next_since_hv = 8'h00;
    end else if (since_hv == 8'hff) begin
      next_since_hv = since_hv;
    end else begin
      next_since_hv = since_hv + 8'h01;
    end
  end

  always_ff @(posedge i_mclk) begin
    since_hv <= i_reset ? 8'hff : next_since_hv;
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  dev_sda_edge_a: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("device data drive changed while clock high");
  ack_hold_a: assert property ($rose(d_sda_oe) |-> d_sda_oe [*8])
    else $error("device data drive released too early");
  out0_latch_a: assert property ($changed(o_out0) |-> !i_latch)
    else $error("output 0 loaded while latch pin high");
  out1_latch_a: assert property ($changed(o_out1) |-> !i_latch)
    else $error("output 1 loaded while latch pin high");
  out_hv_cause_a: assert property (
    ($changed(o_out0) || $changed(o_out1)) |-> since_hv < 8'h20)
    else $error("output loaded without a high-voltage latch fall");
  done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done held longer than one cycle");
  done_idle_a: assert property (o_done |-> !o_busy && scl && sda)
    else $error("transfer done before the bus was released");
  idle_bus_a: assert property (!o_busy |-> scl && sda)
    else $error("bus not released while host idle");
  req_taken_a: assert property (i_req && !o_busy |=> o_busy)
    else $error("request not taken when idle");

  cover property (o_done);
  cover property ($changed(o_out1));
  cover property ($rose(d_sda_oe));
endmodule // dici_checker
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dici_pkg::*;
  logic              i_mclk = 1'b0;
  logic              i_reset;
  logic              host_rst = 1'b0;
  logic              i_req = 1'b0;
  dici_op_e          i_op = OP_WRITE;
  logic [ADDR_W-1:0] i_mem_addr = 5'h00;
  logic [WORD_W-1:0] i_wdata = 16'h0000;
  logic              i_latch = 1'b0;
  logic              i_hv_level = 1'b0;
  logic              o_busy;
  logic              o_done;
  logic              o_nack;
  logic              o_hv_write;
  logic [WORD_W-1:0] o_rdata;
  logic [WORD_W-1:0] o_out0;
  logic [WORD_W-1:0] o_out1;
  int                fail_count = 0;
  int                total_checks = 0;
  int                cyc = 0;
  logic [ADDR_W-1:0] addrs [5] = '{A_CH0, A_CH1, A_CFG8, A_CFG9, A_CFGA};
  logic [WORD_W-1:0] vals [5] = '{16'h1234, 16'h4321, 16'h00ff, 16'hff00,
                                  16'ha55a};

  dici_if bus_if ();

  always #4 i_mclk = ~i_mclk;

  dici_host #(.QUARTER(4)) dici_host_inst (
    .bus(bus_if), .i_mclk(i_mclk), .i_reset(i_reset | host_rst),
    .i_req(i_req), .i_op(i_op), .i_mem_addr(i_mem_addr),
    .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done),
    .o_nack(o_nack), .o_rdata(o_rdata));

  dici_dev #(.DUAL(1'b1)) dici_dev_inst (
    .bus(bus_if), .i_mclk(i_mclk), .i_reset(i_reset), .i_latch(i_latch),
    .i_hv_level(i_hv_level), .o_out0(o_out0), .o_out1(o_out1),
    .o_hv_write(o_hv_write));

  dici_checker dici_checker_inst (
    .i_mclk(i_mclk), .i_reset(i_reset), .scl(bus_if.scl),
    .sda(bus_if.sda), .d_sda_oe(bus_if.d_sda_oe), .i_latch(i_latch),
    .i_hv_level(i_hv_level), .o_out0(o_out0), .o_out1(o_out1),
    .i_req(i_req), .o_busy(o_busy), .o_done(o_done));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [WORD_W-1:0] got,
                     input logic [WORD_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic issue(input dici_op_e op, input logic [ADDR_W-1:0] a,
                       input logic [WORD_W-1:0] d);
    @(posedge i_mclk);
    i_op <= op;
    i_mem_addr <= a;
    i_wdata <= d;
    i_req <= 1'b1;
    @(posedge i_mclk);
    i_req <= 1'b0;
  endtask

  task automatic do_op(input dici_op_e op, input logic [ADDR_W-1:0] a,
                       input logic [WORD_W-1:0] d);
    int n;
    issue(op, a, d);
    n = 0;
    while (o_done !== 1'b1 && n < 2000) begin
      @(posedge i_mclk) #1;
      n++;
    end
    if (n >= 2000) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    end
  endtask

  // Drive the latch pin and its high-voltage level, then let filters settle
  task automatic set_pins(input logic lat, input logic hv);
    @(posedge i_mclk);
    i_latch <= lat;
    i_hv_level <= hv;
    repeat (40) @(posedge i_mclk);
  endtask

  task automatic t_rw();
    for (int i = 0; i < 5; i++) begin
      do_op(OP_WRITE, addrs[i], vals[i]);
      chk({15'h0000, o_nack}, 16'h0000);
    end
    for (int i = 0; i < 5; i++) begin
      do_op(OP_READ, addrs[i], 16'h0000);
      chk(o_rdata, vals[i]);
    end
    chk(o_out0, 16'h0000);
  endtask

  task automatic t_err();
    do_op(OP_WRITE, 5'h02, 16'h1111);
    chk({15'h0000, o_nack}, 16'h0001);
    do_op(OP_WRITE, 5'h0b, 16'h2222);
    chk({15'h0000, o_nack}, 16'h0001);
    do_op(OP_READ_LAST, 5'h00, 16'h0000);
    chk(o_rdata, vals[4]);
    do_op(OP_WRITE, A_CFG8, 16'h5a5a);
    chk({15'h0000, o_nack}, 16'h0000);
  endtask

  task automatic t_latch();
    set_pins(1'b1, 1'b0);
    do_op(OP_READ, A_CH0, 16'h0000);
    chk(o_rdata, 16'h0000);
    set_pins(1'b0, 1'b0);
    chk(o_out0, 16'h0000);
    set_pins(1'b1, 1'b1);
    set_pins(1'b0, 1'b0);
    chk(o_out0, vals[0]);
    chk(o_out1, vals[1]);
  endtask

  task automatic t_hv();
    set_pins(1'b1, 1'b1);
    do_op(OP_WRITE, A_CH0, 16'h0bee);
    chk({15'h0000, o_hv_write}, 16'h0001);
    chk(o_out0, vals[0]);
    do_op(OP_READ, A_CFG8, 16'h0000);
    chk(o_rdata, 16'h5a5a);
    set_pins(1'b0, 1'b0);
    chk(o_out0, 16'h0bee);
    do_op(OP_WRITE, A_CFGA, 16'h0c3c);
    chk({15'h0000, o_hv_write}, 16'h0000);
  endtask

  // Host reset in the low data byte leaves the word unacknowledged
  task automatic t_abort();
    issue(OP_WRITE, A_CFG9, 16'hdead);
    repeat (500) @(posedge i_mclk);
    host_rst <= 1'b1;
    repeat (4) @(posedge i_mclk);
    host_rst <= 1'b0;
    do_op(OP_READ, A_CFG9, 16'h0000);
    chk(o_rdata, vals[3]);
  endtask

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    // A real rising edge is needed to fire the link-side asynchronous resets
    i_reset <= 1'b1;
    repeat (10) @(posedge i_mclk);
    i_reset <= 1'b0;
    t_rw();
    t_err();
    t_latch();
    t_hv();
    t_abort();
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
